// file: src/event_flags_regs.svh
// Behaviour
// - Each tracked event sets its flag bit, which stays set until cleared; middle byte bit 1 instead follows the buffer.
// - Status line active when any flag and its mask are set and legacy mask zero.
// - A nonzero legacy mask makes the extended masks irrelevant to the status line.
// - Reading a flag register returns its value and changes nothing.
// - Writing a flag register stores the AND of current content and written byte, ORed with same-cycle events.
// - Host writes never set flags; internal logic may also clear some.
// - Middle byte bit 0 sets on packet sent, after acknowledgement if requested.
// - Middle byte bit 1 follows buffered received bytes not yet forwarded.
// - Middle byte bit 2 sets on accepted plaintext packet while plaintext is enabled.
// - Middle byte bit 3 sets when the encrypted sequence number goes backward.
// - Middle byte bit 4 sets when the encrypted sequence number skips ahead.
// - Middle byte bit 5 sets when pairing starts.
// - Low byte bit 0 sets on serial receive buffer overflow.
// - Low byte bit 1 sets on radio packet buffer overflow.
// - Low byte bit 2 sets when a register write is rejected or fails.
// - Low byte bit 3 sets when no acknowledgement arrives after all retries.
// - Low byte bit 4 on payload CRC error, bit 5 on header CRC error.
// - Low byte bit 6 on bad ack sequence identifier, bit 7 on bad frame type.
// - Volatile mask bits 0xd0-0xd2 gate same-position flags; saved masks 0x80-0x82 gate nothing.
// - Packet options registers are stored but do not change behaviour.
// - On each join without a same-cycle key generation, hand out next address and increment the last-assigned counter.
// - On new key generation, load the counter with the own administrator address.
`ifndef EVENT_FLAGS_REGS_SVH
`define EVENT_FLAGS_REGS_SVH
`define MASK2_SAVED_ADDR  8'h80
`define MASK1_SAVED_ADDR  8'h81
`define MASK0_SAVED_ADDR  8'h82
`define PACKET_OPTIONS_SAVED_ADDR 8'h83
`define LAST_ADDR_B3_ADDR 8'h8c
`define LAST_ADDR_B2_ADDR 8'h8d
`define LAST_ADDR_B1_ADDR 8'h8e
`define LAST_ADDR_B0_ADDR 8'h8f
`define FLAGS2_ADDR       8'hcd
`define FLAGS1_ADDR       8'hce
`define FLAGS0_ADDR       8'hcf
`define MASK2_ADDR        8'hd0
`define MASK1_ADDR        8'hd1
`define MASK0_ADDR        8'hd2
`define PACKET_OPTIONS_ADDR       8'hd3
`define BYTE_RESET        8'h00
`define WORD_RESET        32'h0000_0000
`define FLAGS1_USED       8'h3f
`define RX_PENDING_BIT    1
`endif

// file: src/event_flags_pkg.sv
package event_flags_pkg;
	typedef logic [7:0]  byte_t;
	typedef logic [31:0] net_addr_t;
endpackage

// file: src/extended_exception_flags.sv
`timescale 1ns/10ps
`include "event_flags_regs.svh"
module extended_exception_flags (
	// Clock and reset
	input  wire logic                      core_clk_i,
	input  wire logic                      rst_i,
	// Register access port
	input  wire logic                      reg_wr_i,
	input  wire logic                      reg_rd_i,
	input  wire event_flags_pkg::byte_t    reg_addr_i,
	input  wire event_flags_pkg::byte_t    reg_wdata_i,
	output event_flags_pkg::byte_t         reg_rdata_o,
	output logic                           reg_rvalid_o,
	// Legacy mask value
	input  wire event_flags_pkg::byte_t    legacy_event_mask_i,
	// Event pulses and level inputs (ack request, rx buffer, plaintext enable), middle byte
	input  wire logic                      tx_done_i,
	input  wire logic                      ack_requested_i,
	input  wire logic                      ack_received_i,
	input  wire logic                      rx_bytes_buffered_i,
	input  wire logic                      plaintext_accepted_i,
	input  wire logic                      accept_plaintext_enable_i,
	input  wire logic                      sequence_backward_i,
	input  wire logic                      sequence_gap_i,
	input  wire logic                      pairing_started_i,
	// Event pulses, low byte
	input  wire logic                      serial_overflow_i,
	input  wire logic                      radio_overflow_i,
	input  wire logic                      reg_write_fail_i,
	input  wire logic                      no_ack_i,
	input  wire logic                      payload_crc_error_i,
	input  wire logic                      header_crc_error_i,
	input  wire logic                      ack_sequence_error_i,
	input  wire logic                      frame_type_error_i,
	// Address administration
	input  wire logic                      unit_joined_i,
	input  wire logic                      key_generated_i,
	input  wire event_flags_pkg::net_addr_t own_address_i,
	output event_flags_pkg::net_addr_t     assigned_address_o,
	// Status
	output logic                           exception_status_line_o
);
	import event_flags_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	byte_t     flags2_r, flags1_r, flags0_r;
	byte_t     mask2_r, mask1_r, mask0_r;
	byte_t     mask2_saved_r, mask1_saved_r, mask0_saved_r;
	byte_t     packet_options_r, packet_options_saved_r;
	net_addr_t last_addr_r;
	logic      tx_wait_ack_r;
	byte_t     set1, set0;
	logic      tx_done_evt;

	function automatic logic wr_hit(input byte_t a);
		wr_hit = reg_wr_i && (reg_addr_i == a);
	endfunction

	// Clearing write: AND with the current content, then OR in new events.
	function automatic byte_t flag_next(input byte_t cur, input byte_t set, input byte_t a);
		flag_next = (wr_hit(a) ? (cur & reg_wdata_i) : cur) | set;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// A send with acknowledgement is held until the acknowledgement lands or no_ack_i releases it.
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			tx_wait_ack_r <= 1'b0;
		end else if (tx_done_i && ack_requested_i && !ack_received_i) begin
			tx_wait_ack_r <= 1'b1;
		end else if (ack_received_i || no_ack_i) begin
			tx_wait_ack_r <= 1'b0;
		end
	end

	assign tx_done_evt = (tx_done_i && (!ack_requested_i || ack_received_i))
		|| (tx_wait_ack_r && ack_received_i);

	always_comb begin
		set1 = 8'h00;
		set1[0] = tx_done_evt;
		set1[2] = plaintext_accepted_i && accept_plaintext_enable_i;
		set1[3] = sequence_backward_i;
		set1[4] = sequence_gap_i;
		set1[5] = pairing_started_i;
		set0 = {frame_type_error_i, ack_sequence_error_i,
			header_crc_error_i, payload_crc_error_i,
			no_ack_i, reg_write_fail_i,
			radio_overflow_i, serial_overflow_i};
	end

	////////////////////////////////////////////////////////////////////////////////
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			flags2_r <= `BYTE_RESET;
			flags1_r <= `BYTE_RESET;
			flags0_r <= `BYTE_RESET;
		end else begin
			flags2_r <= flag_next(flags2_r, 8'h00, `FLAGS2_ADDR);
			flags1_r <= flag_next(flags1_r, set1, `FLAGS1_ADDR) & `FLAGS1_USED;
			// The pending bit mirrors the buffer; a write cannot hide waiting data.
			flags1_r[`RX_PENDING_BIT] <= rx_bytes_buffered_i;
			flags0_r <= flag_next(flags0_r, set0, `FLAGS0_ADDR);
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			mask2_r        <= `BYTE_RESET;
			mask1_r        <= `BYTE_RESET;
			mask0_r        <= `BYTE_RESET;
			mask2_saved_r  <= `BYTE_RESET;
			mask1_saved_r  <= `BYTE_RESET;
			mask0_saved_r  <= `BYTE_RESET;
			packet_options_r       <= `BYTE_RESET;
			packet_options_saved_r <= `BYTE_RESET;
		end else begin
			if (wr_hit(`MASK2_ADDR)) mask2_r <= reg_wdata_i;
			if (wr_hit(`MASK1_ADDR)) mask1_r <= reg_wdata_i;
			if (wr_hit(`MASK0_ADDR)) mask0_r <= reg_wdata_i;
			if (wr_hit(`MASK2_SAVED_ADDR)) mask2_saved_r <= reg_wdata_i;
			if (wr_hit(`MASK1_SAVED_ADDR)) mask1_saved_r <= reg_wdata_i;
			if (wr_hit(`MASK0_SAVED_ADDR)) mask0_saved_r <= reg_wdata_i;
			// Stored only; nothing but the register read path reads it.
			if (wr_hit(`PACKET_OPTIONS_ADDR)) packet_options_r <= reg_wdata_i;
			if (wr_hit(`PACKET_OPTIONS_SAVED_ADDR)) packet_options_saved_r <= reg_wdata_i;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			last_addr_r        <= `WORD_RESET;
			assigned_address_o <= `WORD_RESET;
		end else begin
			if (key_generated_i) begin
				last_addr_r <= own_address_i;
			end else if (unit_joined_i) begin
				last_addr_r        <= last_addr_r + 32'h0000_0001;
				assigned_address_o <= last_addr_r + 32'h0000_0001;
			end else begin
				if (wr_hit(`LAST_ADDR_B3_ADDR)) last_addr_r[31:24] <= reg_wdata_i;
				if (wr_hit(`LAST_ADDR_B2_ADDR)) last_addr_r[23:16] <= reg_wdata_i;
				if (wr_hit(`LAST_ADDR_B1_ADDR)) last_addr_r[15:8]  <= reg_wdata_i;
				if (wr_hit(`LAST_ADDR_B0_ADDR)) last_addr_r[7:0]   <= reg_wdata_i;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			exception_status_line_o <= 1'b0;
		end else begin
			exception_status_line_o <= (legacy_event_mask_i == 8'h00) &&
				(|((flags2_r & mask2_r) | (flags1_r & mask1_r) | (flags0_r & mask0_r)));
		end
	end

	// Reads have no side effect on any flag.
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			reg_rdata_o  <= `BYTE_RESET;
			reg_rvalid_o <= 1'b0;
		end else begin
			reg_rvalid_o <= reg_rd_i;
			if (reg_rd_i) begin
				if (reg_addr_i == `FLAGS2_ADDR) reg_rdata_o <= flags2_r;
				else if (reg_addr_i == `FLAGS1_ADDR) reg_rdata_o <= flags1_r;
				else if (reg_addr_i == `FLAGS0_ADDR) reg_rdata_o <= flags0_r;
				else if (reg_addr_i == `MASK2_ADDR) reg_rdata_o <= mask2_r;
				else if (reg_addr_i == `MASK1_ADDR) reg_rdata_o <= mask1_r;
				else if (reg_addr_i == `MASK0_ADDR) reg_rdata_o <= mask0_r;
				else if (reg_addr_i == `PACKET_OPTIONS_ADDR) reg_rdata_o <= packet_options_r;
				else if (reg_addr_i == `MASK2_SAVED_ADDR) reg_rdata_o <= mask2_saved_r;
				else if (reg_addr_i == `MASK1_SAVED_ADDR) reg_rdata_o <= mask1_saved_r;
				else if (reg_addr_i == `MASK0_SAVED_ADDR) reg_rdata_o <= mask0_saved_r;
				else if (reg_addr_i == `PACKET_OPTIONS_SAVED_ADDR) reg_rdata_o <= packet_options_saved_r;
				else if (reg_addr_i == `LAST_ADDR_B3_ADDR) reg_rdata_o <= last_addr_r[31:24];
				else if (reg_addr_i == `LAST_ADDR_B2_ADDR) reg_rdata_o <= last_addr_r[23:16];
				else if (reg_addr_i == `LAST_ADDR_B1_ADDR) reg_rdata_o <= last_addr_r[15:8];
				else if (reg_addr_i == `LAST_ADDR_B0_ADDR) reg_rdata_o <= last_addr_r[7:0];
				else reg_rdata_o <= 8'h00;
			end
		end
	end
endmodule

// file: verification/ext_flags_sva.sv
`timescale 1ns/10ps
module ext_flags_sva (
	// Observed ports
	input wire logic                       core_clk_i,
	input wire logic                       rst_i,
	input wire logic                       reg_rd_i,
	input wire event_flags_pkg::byte_t     reg_addr_i,
	input wire event_flags_pkg::byte_t     reg_rdata_o,
	input wire logic                       reg_rvalid_o,
	input wire event_flags_pkg::byte_t     legacy_event_mask_i,
	input wire logic                       rx_bytes_buffered_i,
	input wire logic                       unit_joined_i,
	input wire logic                       key_generated_i,
	input wire event_flags_pkg::net_addr_t assigned_address_o,
	input wire logic                       exception_status_line_o
);
	import event_flags_pkg::*;
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (rst_i);
	a_read_answered: assert property (reg_rd_i |=> reg_rvalid_o)
		else $error("read not answered");
	a_no_stray_valid: assert property (!reg_rd_i |=> !reg_rvalid_o)
		else $error("stray read valid");
	a_rdata_holds: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
		else $error("read data moved");
	a_legacy_blocks: assert property (legacy_event_mask_i != 8'h00 |=> !exception_status_line_o)
		else $error("status line despite legacy mask");
	a_upper_empty: assert property (reg_rd_i && reg_addr_i == 8'hcd |=> reg_rdata_o == 8'h00)
		else $error("reserved flag byte not zero");
	a_rx_follows: assert property (reg_rd_i && reg_addr_i == 8'hce
		|=> reg_rdata_o[1] == $past(rx_bytes_buffered_i, 2)) else $error("rx pending wrong");
	a_join_counts: assert property ((unit_joined_i && !key_generated_i) ##1 unit_joined_i
		|=> assigned_address_o == $past(assigned_address_o) + 32'h1) else $error("join count");
	a_addr_steady: assert property (!unit_joined_i |=> $stable(assigned_address_o))
		else $error("address moved without join");
endmodule
bind extended_exception_flags ext_flags_sva chk (.*);

// file: verification/host_model.sv
`timescale 1ns/10ps
module host_model (
	// Register bus, driven from the host side
	input  wire logic              core_clk_i,
	input  wire event_flags_pkg::byte_t reg_rdata_i,
	output event_flags_pkg::byte_t reg_addr_o,
	output event_flags_pkg::byte_t reg_wdata_o,
	output logic                   reg_wr_o,
	output logic                   reg_rd_o
);
	import event_flags_pkg::*;
	initial {reg_wr_o, reg_rd_o, reg_addr_o, reg_wdata_o} = 18'h0;
	// Released address and data are inverted so a stale value is never mistaken for a request.
	task automatic wr(input byte_t a, input byte_t d);
		byte_t v;
		v = (a inside {8'h80, 8'hd0}) ? 8'h00 : d;
		if (a inside {8'h81, 8'hd1}) v = d & 8'h3f;
		@(posedge core_clk_i);
		{reg_wr_o, reg_addr_o, reg_wdata_o} <= {1'b1, a, v};
		@(posedge core_clk_i);
		{reg_wr_o, reg_addr_o, reg_wdata_o} <= {1'b0, ~a, ~v};
	endtask
	task automatic rd(input byte_t a, output byte_t d);
		@(posedge core_clk_i);
		{reg_rd_o, reg_addr_o} <= {1'b1, a};
		@(posedge core_clk_i);
		{reg_rd_o, reg_addr_o} <= {1'b0, ~a};
		@(negedge core_clk_i);
		d = reg_rdata_i;
	endtask
endmodule

// file: verification/tb_top.sv
`timescale 1ns/10ps
module tb_top;
	import event_flags_pkg::*;
	logic        core_clk_i = 1'b0, rst_i = 1'b1, reg_wr_i, reg_rd_i, reg_rvalid_o;
	logic        ack_requested_i = 1'b0, rx_bytes_buffered_i = 1'b0, exception_status_line_o;
	logic        accept_plaintext_enable_i = 1'b1;
	logic [15:0] ev = 16'h0;
	byte_t       reg_addr_i, reg_wdata_i, reg_rdata_o, legacy_event_mask_i = 8'h00;
	net_addr_t   own_address_i = 32'h0, assigned_address_o;
	int          error_cnt = 0, check_count = 0;
	host_model host (.core_clk_i, .reg_addr_o(reg_addr_i), .reg_wdata_o(reg_wdata_i),
		.reg_wr_o(reg_wr_i), .reg_rd_o(reg_rd_i), .reg_rdata_i(reg_rdata_o));
	extended_exception_flags dut (.*, .tx_done_i(ev[8]), .ack_received_i(ev[13]),
		.plaintext_accepted_i(ev[9]), .sequence_backward_i(ev[10]), .sequence_gap_i(ev[11]),
		.pairing_started_i(ev[12]), .serial_overflow_i(ev[0]), .radio_overflow_i(ev[1]),
		.reg_write_fail_i(ev[2]), .no_ack_i(ev[3]), .payload_crc_error_i(ev[4]),
		.header_crc_error_i(ev[5]), .ack_sequence_error_i(ev[6]), .frame_type_error_i(ev[7]),
		.unit_joined_i(ev[14]), .key_generated_i(ev[15]));
	always #12.5 core_clk_i = ~core_clk_i;
	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input string n, input net_addr_t e, input net_addr_t g);
		check_count++;
		if (g !== e) begin
			error_cnt++;
			$display("BAD %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic rdc(input byte_t a, input byte_t e);
		byte_t d;
		host.rd(a, d);
		chk("register", {24'h0, e}, {24'h0, d});
	endtask
	task automatic pulse(input logic [15:0] v);
		@(posedge core_clk_i);
		ev <= v;
	endtask
	// The line is registered behind registered flags, so three falling edges cover it.
	task automatic line_is(input logic e);
		repeat (3) @(negedge core_clk_i);
		chk("line", {31'h0, e}, {31'h0, exception_status_line_o});
	endtask
	////////////////////////////////////////////////////////////////////////////////
	task automatic s_regs();
		byte_t al[15] = '{8'h80, 8'h81, 8'h82, 8'h83, 8'h8c, 8'h8d, 8'h8e, 8'h8f,
			8'hcd, 8'hce, 8'hcf, 8'hd0, 8'hd1, 8'hd2, 8'h00};
		byte_t e;
		foreach (al[i]) begin
			rdc(al[i], 8'h00);
			host.wr(al[i], 8'hff);
			e = (al[i] inside {8'h81, 8'hd1}) ? 8'h3f : 8'hff;
			if (al[i] inside {8'h00, 8'h80, 8'hd0, 8'hcd, 8'hce, 8'hcf}) e = 8'h00;
			rdc(al[i], e);
			host.wr(al[i], 8'h00);
		end
	endtask
	task automatic s_events();
		byte_t a;
		byte_t b;
		for (int i = 0; i < 13; i++) begin
			pulse(16'h1 << i);
			pulse(16'h0);
			a = (i < 8) ? 8'hcf : 8'hce;
			b = (i < 8) ? 8'h1 << i : ((i == 8) ? 8'h01 : 8'h1 << (i - 7));
			rdc(a, b);
			rdc(a, b);
			host.wr(a, ~b);
			rdc(a, 8'h00);
		end
		@(posedge core_clk_i);
		{accept_plaintext_enable_i, ack_requested_i} <= 2'b01;
		pulse(16'h0300);
		pulse(16'h0);
		rdc(8'hce, 8'h00);
		pulse(16'h2000);
		pulse(16'h0);
		rdc(8'hce, 8'h01);
		host.wr(8'hce, 8'h00);
		{ack_requested_i, rx_bytes_buffered_i} <= 2'b01;
		host.wr(8'hce, 8'h00);
		rdc(8'hce, 8'h02);
		@(posedge core_clk_i);
		rx_bytes_buffered_i <= 1'b0;
		rdc(8'hce, 8'h00);
		fork
			host.wr(8'hcf, 8'h00);
			pulse(16'h0001);
		join
		pulse(16'h0);
		rdc(8'hcf, 8'h01);
	endtask
	task automatic s_line();
		host.wr(8'h82, 8'h01);
		line_is(1'b0);
		host.wr(8'hd2, 8'h01);
		line_is(1'b1);
		@(posedge core_clk_i);
		legacy_event_mask_i <= 8'h04;
		line_is(1'b0);
		@(posedge core_clk_i);
		legacy_event_mask_i <= 8'h00;
		line_is(1'b1);
		host.wr(8'hcf, 8'hfe);
		line_is(1'b0);
	endtask
	task automatic s_join();
		@(posedge core_clk_i);
		own_address_i <= 32'h1234_5678;
		pulse(16'h8000);
		pulse(16'h4000);
		pulse(16'h4000);
		pulse(16'h0);
		@(negedge core_clk_i);
		chk("assigned", 32'h1234_567a, assigned_address_o);
		rdc(8'h8f, 8'h7a);
		rdc(8'h8c, 8'h12);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	task automatic report_and_stop();
		$display("errors %0d checks %0d", error_cnt, check_count);
		if (error_cnt == 0 && check_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	initial begin
		repeat (4) @(posedge core_clk_i);
		rst_i <= 1'b0;
		s_regs();
		s_events();
		s_line();
		s_join();
		report_and_stop();
	end
	initial begin
		repeat (20000) @(posedge core_clk_i);
		error_cnt++;
		report_and_stop();
	end
endmodule
